// >>> core/spm_pkg.sv
// Purpose: Shared constants for the serial port block (modes 0 to 2)
// Assumes: One 8-bit register port with 2-bit address, 25 MHz clock = oscillator
// Notes:   Register offsets and control bit positions are fixed here
package spm_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] ADDR_BUFFER  = 2'h0;
    localparam logic [1:0] ADDR_CONTROL = 2'h1;
    localparam logic [1:0] ADDR_POWER   = 2'h2;

    // Serial control field positions
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_QUAL    = 5;
    localparam int CTL_REN     = 4;
    localparam int CTL_TB8     = 3;
    localparam int CTL_RB8     = 2;
    localparam int CTL_TI      = 1;
    localparam int CTL_RI      = 0;
    // Power control field position
    localparam int PWR_DOUBLE  = 7;

    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] PWR_RESET = 8'h00;
    localparam logic       LINE_IDLE = 1'b1;

    // Operating modes
    typedef enum logic [1:0] {
        SPM_MODE_SYNC   = 2'b00,
        SPM_MODE_TIMER  = 2'b01,
        SPM_MODE_OSC    = 2'b10,
        SPM_MODE_UNUSED = 2'b11
    } spm_mode_e;

    // Asynchronous receiver states
    typedef enum logic [1:0] {
        SPM_RX_IDLE  = 2'b00,
        SPM_RX_START = 2'b01,
        SPM_RX_DATA  = 2'b10,
        SPM_RX_STOP  = 2'b11
    } spm_rx_e;

    // Mode 0 bit timing, in clock periods
    localparam logic [3:0] M0_SLOW_PERIOD = 4'hc;
    localparam logic [3:0] M0_SLOW_FALL   = 4'h3;
    localparam logic [3:0] M0_SLOW_LOW    = 4'h6;
    localparam logic [3:0] M0_FAST_PERIOD = 4'h4;
    localparam logic [3:0] M0_FAST_FALL   = 4'h1;
    localparam logic [3:0] M0_FAST_LOW    = 4'h2;
    localparam logic [2:0] M0_LAST_BIT    = 3'h7;

    // Oversampling counter states (8th, 9th, 10th) and rollover state
    localparam logic [3:0] OVS_SAMPLE_A = 4'h7;
    localparam logic [3:0] OVS_SAMPLE_B = 4'h8;
    localparam logic [3:0] OVS_SAMPLE_C = 4'h9;
    localparam logic [3:0] OVS_LAST     = 4'hf;

    // Frame lengths and last data bit indices
    localparam logic [3:0] M1_FRAME_BITS = 4'ha;
    localparam logic [3:0] M2_FRAME_BITS = 4'hb;
    localparam logic [3:0] M1_LAST_DATA  = 4'h7;
    localparam logic [3:0] M2_LAST_DATA  = 4'h8;
endpackage : spm_pkg

// >>> core/spm_serial_port.sv
// Purpose: Serial port, synchronous mode 0 and asynchronous modes 1 and 2
// Assumes: timer_overflow is a one-cycle pulse from logic on the same clock
// Notes:   Mode 3 code selects no engine; the port then stays idle
//
// Functional notes
// - Buffer write loads transmitter, read returns receiver
// - Mode 0: data on rxd, clock on txd
// - Mode 0 rate twelfth or quarter by qualifier
// - Fast mode 0: data 1 before fall, low 2
// - Slow mode 0: data 3 before fall, low 6
// - Mode 0 transmit flag set after eighth bit
// - Mode 0 receive needs enable and clear flag
// - Mode 0 receive flag set, blocks further reception
// - Mode 1 ten-bit frame, stop into ninth
// - Mode 1 rate from timer overflow divided
// - Async transmit bits follow divide-by-16 rollovers
// - Mode 1 transmit flag at tenth rollover
// - Falling edge resets receive oversampling counter
// - Majority of samples 8, 9, 10
// - Non-zero start bit aborts reception at once
// - Mode 1 accept only if flag clear, qualified
// - Search resumes in middle of stop bit
// - Mode 2 eleven-bit frame with ninth bit
// - Mode 2 rate oscillator by 16 or 32
// - Mode 2 transmit flag at eleventh rollover
// - Mode 2 accept only if flag clear, qualified
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module spm_serial_port #(
    parameter int DATA_W = 8                   // Register and character width
) (
    input  wire logic       clock,             // 25 MHz oscillator clock
    input  wire logic       rst_b,             // Async reset, active low
    input  wire logic [1:0] addr,              // Register offset
    input  wire logic [7:0] wdata,             // Write data
    input  wire logic       wr,                // Write strobe
    input  wire logic       rd,                // Read strobe
    output logic      [7:0] rdata,             // Read data, cycle after rd
    input  wire logic       timer_overflow,    // Timer 1 overflow pulse
    input  wire logic       rxd_in,            // Receive data pin level
    output logic            rxd_out,           // Mode 0 transmit data
    output logic            rxd_oe_b,          // Low while driving rxd
    output logic            txd                // Serial out or shift clock
);
    // Only 8-bit characters are served by the shifters below
    if (DATA_W != 8) begin : g_width_check
        $error("spm_serial_port: DATA_W must be 8");
    end

    // Picks the slow or fast mode 0 timing figure
    function automatic logic [3:0] m0_pick(input logic fast, input logic [3:0] slow_v,
                                           input logic [3:0] fast_v);
        m0_pick = fast ? fast_v : slow_v;
    endfunction : m0_pick

    // Control and status
    spm_pkg::spm_mode_e mode;                  // Operating mode
    logic               qual;                  // Mode qualifier bit
    logic               ren;                   // Receive enable
    logic               tb8;                   // Transmit ninth bit
    logic               rb8;                   // Received ninth bit
    logic               ti;                    // Transmit complete flag
    logic               ri;                    // Receive flag
    logic               dbl;                   // Baud double select
    logic [7:0]         rx_buf;                // Receive buffer

    // Pin synchroniser: first stage feeds only the second
    logic               rxd_meta;              // First stage
    logic               rxd_sync;              // Second stage
    logic               rxd_prev;              // Edge history

    // Baud tick generation
    logic               tick_half;             // Divide-by-2 toggle
    logic [3:0]         tx_div;                // Transmit divide-by-16
    logic [3:0]         rx_div;                // Receive divide-by-16

    // Async transmitter
    logic [10:0]        tx_shift;              // Frame shifter
    logic [3:0]         tx_left;               // Bits still to drive
    logic               tx_busy;               // Frame in flight
    logic               tx_line;               // Line level
    logic               tx_done;               // Last bit driven pulse

    // Async receiver
    spm_pkg::spm_rx_e   rx_state;              // Receiver state
    logic [8:0]         rx_shift;              // Incoming bits
    logic [3:0]         rx_count;              // Data bits taken
    logic [1:0]         votes;                 // Early samples

    // Mode 0 sequencer
    logic               m0_busy;               // Frame running
    logic               m0_rx;                 // Direction is receive
    logic               m0_fast;               // Rate latched at start
    logic [3:0]         m0_phase;              // Position in bit time
    logic [2:0]         m0_bit;                // Bit index
    logic [7:0]         m0_shift;              // Shift register
    logic               shift_clk;             // Shift clock level
    logic               m0_done_tx;            // Transmit finished pulse
    logic               m0_done_rx;            // Receive finished pulse

    // Bus decode
    wire bus_buf_wr  = wr && (addr == spm_pkg::ADDR_BUFFER);
    wire bus_ctl_wr  = wr && (addr == spm_pkg::ADDR_CONTROL);
    wire bus_pwr_wr  = wr && (addr == spm_pkg::ADDR_POWER);
    wire is_sync     = (mode == spm_pkg::SPM_MODE_SYNC);
    wire is_osc      = (mode == spm_pkg::SPM_MODE_OSC);
    wire is_async    = (mode == spm_pkg::SPM_MODE_TIMER) || is_osc;

    // Oversampling tick: oscillator in mode 2, timer overflow in mode 1
    wire tick_src    = is_osc ? 1'b1 : timer_overflow;
    wire tick        = tick_src && (dbl || tick_half);
    wire tx_roll     = tick && (tx_div == spm_pkg::OVS_LAST);
    wire rx_decide   = tick && (rx_div == spm_pkg::OVS_SAMPLE_C);
    wire rx_bit      = (votes[0] & votes[1]) | (votes[0] & rxd_sync)
                     | (votes[1] & rxd_sync);
    wire rx_fall     = rxd_prev && !rxd_sync;

    // Mode 0 timing points
    wire [3:0] m0_fall = m0_pick(m0_fast, spm_pkg::M0_SLOW_FALL, spm_pkg::M0_FAST_FALL);
    wire [3:0] m0_rise = m0_fall
                       + m0_pick(m0_fast, spm_pkg::M0_SLOW_LOW, spm_pkg::M0_FAST_LOW);
    wire [3:0] m0_end  = m0_pick(m0_fast, spm_pkg::M0_SLOW_PERIOD,
                                 spm_pkg::M0_FAST_PERIOD) - 4'h1;
    wire m0_last       = (m0_phase == m0_end);
    wire [3:0] m0_next = m0_phase + 4'h1;                                 // Phase after this edge
    // Clock moves on the edge into its phase, so the level holds for that whole phase
    wire m0_go_low     = (m0_next == m0_fall);
    // At the quarter rate the low time is shorter than the pin synchroniser,
    // so a partner that answers the falling edge is not seen in time
    wire m0_go_high    = (m0_next == m0_rise);

    // Start conditions; writes during a running frame are dropped
    wire m0_tx_start = bus_buf_wr && is_sync && !m0_busy;
    // The flag lands a cycle after the frame ends; wait for it before restarting
    wire m0_rx_start = is_sync && ren && !ri && !m0_busy && !bus_buf_wr
                     && !m0_done_rx;
    wire tx_start    = bus_buf_wr && is_async && !tx_busy;

    // Receive frame interpretation
    wire       last_data = (rx_count == (is_osc ? spm_pkg::M2_LAST_DATA
                                                : spm_pkg::M1_LAST_DATA));
    wire [7:0] rx_data   = is_osc ? rx_shift[7:0] : rx_shift[8:1];
    wire       rx_ninth  = is_osc ? rx_shift[8] : rx_bit;
    wire rx_accept = (rx_state == spm_pkg::SPM_RX_STOP) && rx_decide
                   && !ri && (!qual || rx_ninth);

    // Flag set events, set wins over a software clear
    wire ti_set = m0_done_tx || tx_done;
    wire ri_set = m0_done_rx || rx_accept;

    // Two-stage synchroniser on the receive pin
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxd_meta <= spm_pkg::LINE_IDLE;
            rxd_sync <= spm_pkg::LINE_IDLE;
            rxd_prev <= spm_pkg::LINE_IDLE;
        end
        else
        begin
            rxd_meta <= rxd_in;
            rxd_sync <= rxd_meta;
            rxd_prev <= rxd_sync;
        end
    end

    // Control register and flags
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode <= spm_pkg::SPM_MODE_SYNC;
            qual <= spm_pkg::CTL_RESET[spm_pkg::CTL_QUAL];
            ren  <= spm_pkg::CTL_RESET[spm_pkg::CTL_REN];
            tb8  <= spm_pkg::CTL_RESET[spm_pkg::CTL_TB8];
            rb8  <= spm_pkg::CTL_RESET[spm_pkg::CTL_RB8];
            ti   <= spm_pkg::CTL_RESET[spm_pkg::CTL_TI];
            ri   <= spm_pkg::CTL_RESET[spm_pkg::CTL_RI];
            dbl  <= spm_pkg::PWR_RESET[spm_pkg::PWR_DOUBLE];
        end
        else
        begin
            if (bus_ctl_wr)
            begin
                mode <= spm_pkg::spm_mode_e'(wdata[spm_pkg::CTL_MODE_HI:spm_pkg::CTL_MODE_LO]);
                qual <= wdata[spm_pkg::CTL_QUAL];
                ren  <= wdata[spm_pkg::CTL_REN];
                tb8  <= wdata[spm_pkg::CTL_TB8];
            end
            if (bus_pwr_wr)
                dbl <= wdata[spm_pkg::PWR_DOUBLE];
            // Hardware load of the ninth bit beats software
            if (rx_accept)
                rb8 <= rx_ninth;
            else if (bus_ctl_wr)
                rb8 <= wdata[spm_pkg::CTL_RB8];
            ti <= (bus_ctl_wr ? wdata[spm_pkg::CTL_TI] : ti) | ti_set;
            ri <= (bus_ctl_wr ? wdata[spm_pkg::CTL_RI] : ri) | ri_set;
        end
    end

    // Receive buffer, loaded by either engine
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rx_buf <= 8'h00;
        else if (rx_accept)
            rx_buf <= rx_data;
        else if (m0_done_rx)
            rx_buf <= m0_shift;
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 8'h00;
        else if (rd)
        begin
            case (addr)
                spm_pkg::ADDR_BUFFER:  rdata <= rx_buf;
                spm_pkg::ADDR_CONTROL: rdata <= {mode, qual, ren, tb8, rb8, ti, ri};
                spm_pkg::ADDR_POWER:   rdata <= {dbl, 7'h00};
                default:               rdata <= 8'h00;
            endcase
        end
    end

    // Baud dividers; the transmit counter runs free
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_half <= 1'b0;
            tx_div    <= 4'h0;
        end
        else
        begin
            if (tick_src)
                tick_half <= !tick_half;
            if (tick)
                tx_div <= tx_div + 4'h1;
        end
    end

    // Async transmitter: bits move only on rollovers, not on the write
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_shift <= 11'h7ff;
            tx_left  <= 4'h0;
            tx_busy  <= 1'b0;
            tx_line  <= spm_pkg::LINE_IDLE;
            tx_done  <= 1'b0;
        end
        else
        begin
            tx_done <= 1'b0;
            if (tx_start)
            begin
                tx_busy  <= 1'b1;
                tx_shift <= {1'b1, (is_osc ? tb8 : 1'b1), wdata, 1'b0};
                tx_left  <= is_osc ? spm_pkg::M2_FRAME_BITS : spm_pkg::M1_FRAME_BITS;
            end
            else if (tx_busy && tx_roll)
            begin
                tx_line  <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_left  <= tx_left - 4'h1;
                if (tx_left == 4'h1)
                begin
                    tx_busy <= 1'b0;
                    tx_done <= 1'b1;
                end
            end
        end
    end

    // Async receiver with edge search and three-sample vote
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_state <= spm_pkg::SPM_RX_IDLE;
            rx_div   <= 4'h0;
            rx_shift <= 9'h000;
            rx_count <= 4'h0;
            votes    <= 2'b11;
        end
        else
        begin
            if (tick && rx_div == spm_pkg::OVS_SAMPLE_A)
                votes[0] <= rxd_sync;
            if (tick && rx_div == spm_pkg::OVS_SAMPLE_B)
                votes[1] <= rxd_sync;
            if (tick)
                rx_div <= rx_div + 4'h1;
            case (rx_state)
                spm_pkg::SPM_RX_IDLE:
                begin
                    if (is_async && ren && rx_fall)
                    begin
                        rx_div   <= 4'h0;
                        rx_count <= 4'h0;
                        rx_state <= spm_pkg::SPM_RX_START;
                    end
                end
                spm_pkg::SPM_RX_START:
                begin
                    if (rx_decide)
                        rx_state <= rx_bit ? spm_pkg::SPM_RX_IDLE
                                           : spm_pkg::SPM_RX_DATA;
                end
                spm_pkg::SPM_RX_DATA:
                begin
                    if (rx_decide)
                    begin
                        rx_shift <= {rx_bit, rx_shift[8:1]};
                        rx_count <= rx_count + 4'h1;
                        if (last_data)
                            rx_state <= spm_pkg::SPM_RX_STOP;
                    end
                end
                spm_pkg::SPM_RX_STOP:
                begin
                    // Decided in mid stop bit; searching resumes here
                    if (rx_decide)
                        rx_state <= spm_pkg::SPM_RX_IDLE;
                end
                default: rx_state <= spm_pkg::SPM_RX_IDLE;
            endcase
            // Leaving the async modes or disabling drops a frame
            if (!is_async || !ren)
                rx_state <= spm_pkg::SPM_RX_IDLE;
        end
    end

    // Mode 0 sequencer; rate latched so a mid-frame write cannot warp it
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            m0_busy    <= 1'b0;
            m0_rx      <= 1'b0;
            m0_fast    <= 1'b0;
            m0_phase   <= 4'h0;
            m0_bit     <= 3'h0;
            m0_shift   <= 8'h00;
            shift_clk  <= 1'b1;
            m0_done_tx <= 1'b0;
            m0_done_rx <= 1'b0;
        end
        else
        begin
            m0_done_tx <= 1'b0;
            m0_done_rx <= 1'b0;
            if (!m0_busy)
            begin
                m0_phase <= 4'h0;
                m0_bit   <= 3'h0;
                if (m0_tx_start || m0_rx_start)
                begin
                    m0_busy  <= 1'b1;
                    m0_rx    <= m0_rx_start;
                    m0_fast  <= qual;
                    m0_shift <= m0_tx_start ? wdata : 8'h00;
                end
            end
            else
            begin
                m0_phase <= m0_last ? 4'h0 : m0_phase + 4'h1;
                if (m0_go_low)
                    shift_clk <= 1'b0;
                if (m0_go_high)
                begin
                    shift_clk <= 1'b1;
                    if (m0_rx)
                        m0_shift <= {rxd_sync, m0_shift[7:1]};
                end
                if (m0_last)
                begin
                    m0_bit <= m0_bit + 3'h1;
                    if (!m0_rx)
                        m0_shift <= {1'b0, m0_shift[7:1]};
                    if (m0_bit == spm_pkg::M0_LAST_BIT)
                    begin
                        m0_busy    <= 1'b0;
                        m0_done_tx <= !m0_rx;
                        m0_done_rx <= m0_rx;
                    end
                end
            end
        end
    end

    // Pin drivers, all registered
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txd      <= spm_pkg::LINE_IDLE;
            rxd_out  <= spm_pkg::LINE_IDLE;
            rxd_oe_b <= 1'b1;
        end
        else
        begin
            txd      <= is_sync ? shift_clk : tx_line;
            rxd_out  <= m0_shift[0];
            rxd_oe_b <= !(m0_busy && !m0_rx);
        end
    end

    // Checks
    sequence s_low6;
        !shift_clk [*6] ##1 shift_clk;
    endsequence
    sequence s_low2;
        !shift_clk [*2] ##1 shift_clk;
    endsequence

    property p_slow_low;
        @(posedge clock) disable iff (!rst_b)
        (m0_busy && !m0_fast && $fell(shift_clk)) |-> s_low6;
    endproperty
    a_slow_low: assert property (p_slow_low) else $error("slow clock low time");

    property p_fast_low;
        @(posedge clock) disable iff (!rst_b)
        (m0_busy && m0_fast && $fell(shift_clk)) |-> s_low2;
    endproperty
    a_fast_low: assert property (p_fast_low) else $error("fast clock low time");

    property p_m0_ti;
        @(posedge clock) disable iff (!rst_b)
        m0_done_tx |=> ti;
    endproperty
    a_m0_ti: assert property (p_m0_ti) else $error("mode 0 transmit flag");

    property p_m0_ri;
        @(posedge clock) disable iff (!rst_b)
        m0_done_rx |=> ri && rx_buf == $past(m0_shift);
    endproperty
    a_m0_ri: assert property (p_m0_ri) else $error("mode 0 receive flag");

    property p_m0_rx_gate;
        @(posedge clock) disable iff (!rst_b)
        $rose(m0_busy) && m0_rx |-> $past(ren && !ri);
    endproperty
    a_m0_rx_gate: assert property (p_m0_rx_gate) else $error("mode 0 receive gate");

    property p_buf_read;
        @(posedge clock) disable iff (!rst_b)
        rd && addr == spm_pkg::ADDR_BUFFER |=> rdata == $past(rx_buf);
    endproperty
    a_buf_read: assert property (p_buf_read) else $error("buffer read data");

    property p_edge_align;
        @(posedge clock) disable iff (!rst_b)
        rx_state == spm_pkg::SPM_RX_IDLE && is_async && ren && rx_fall
        |=> rx_div == 4'h0 && rx_state == spm_pkg::SPM_RX_START;
    endproperty
    a_edge_align: assert property (p_edge_align) else $error("edge align");

    property p_bad_start;
        @(posedge clock) disable iff (!rst_b)
        rx_state == spm_pkg::SPM_RX_START && rx_decide && rx_bit
        |=> rx_state == spm_pkg::SPM_RX_IDLE;
    endproperty
    a_bad_start: assert property (p_bad_start) else $error("start abort");

    property p_accept;
        @(posedge clock) disable iff (!rst_b)
        rx_accept |=> ri && rb8 == $past(rx_ninth) && rx_state == spm_pkg::SPM_RX_IDLE;
    endproperty
    a_accept: assert property (p_accept) else $error("frame accept");

    property p_tx_ti;
        @(posedge clock) disable iff (!rst_b)
        tx_done |-> ti ##0 1'b1 or ##1 ti;
    endproperty
    a_tx_ti: assert property (p_tx_ti) else $error("async transmit flag");
endmodule : spm_serial_port
`default_nettype wire

// >>> tb/spm_partner.sv
// Purpose: Far side model, shift register and async line
// Assumes: Shift clock idles high between frames
// Notes:   Async frames come from the bench line
`timescale 1ns/1ps
`default_nettype none
module spm_partner (
    input  wire logic       sclk,       // Shift clock from device
    input  wire logic       rst_b,      // Bench reset, active low
    input  wire logic       pin,        // Resolved data pin
    input  wire logic       async_sel,  // Pass async line
    input  wire logic       async_line, // Async frame bits
    input  wire logic [7:0] tx_byte,    // Byte to shift in
    output logic            drv,        // Partner drive
    output logic      [7:0] got         // Captured byte
);
    logic [2:0] r = 3'h0; // Rising edges seen
    logic       d = 1'b0; // Shift data
    // New bit only after a fall, so it is settled at the rise
    always @(negedge sclk) d <= tx_byte[r];
    // Capture on rise, LSB first
    always @(posedge sclk)
    begin
        got <= {pin, got[7:1]};
        // The unknown-to-high step of the clock in reset is not a bit
        r   <= rst_b ? r + 3'h1 : 3'h0;
    end
    assign drv = async_sel ? async_line : d;
endmodule : spm_partner
`default_nettype wire

// >>> tb/serial_port_modes_0_to_2_bench.sv
// Purpose: Bench for the serial port, modes 0 to 2
// Assumes: Timer tick every second clock
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none
module serial_port_modes_0_to_2_bench;
    logic       clock = 0, rst_b = 0, wr = 0, rd = 0, tov = 0;
    logic [1:0] addr = 0;
    logic [7:0] wdata = 0, rdata, got, v, tx_byte = 8'h3c;
    logic       rxd_out, rxd_oe_b, txd, pin, drv;
    logic       async_sel = 0, async_line = 1;
    logic [10:0] frm;
    int         bad_count = 0, tests_run = 0;
    initial forever #20 clock = ~clock;
    always @(posedge clock) tov <= ~tov; // Slow tick for mode 1
    assign pin = rxd_oe_b ? drv : rxd_out; // Device wins when driving
    spm_serial_port u_spm_serial_port (.clock(clock), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_overflow(tov),
        .rxd_in(pin), .rxd_out(rxd_out), .rxd_oe_b(rxd_oe_b), .txd(txd));
    spm_partner u_spm_partner (.sclk(txd), .rst_b(rst_b), .pin(pin), .async_sel(async_sel),
        .async_line(async_line), .tx_byte(tx_byte), .drv(drv), .got(got));
    task automatic complete_run;
        $display("Checks %0d, errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clock);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        {rd, addr} <= {1'b1, a};
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata; // Held until the next read
    endtask : rreg
    // Bounded poll of one control bit
    task automatic wait_bit(input int b);
        for (int i = 0; i < 400; i++)
        begin
            rreg(2'h1, v);
            if (v[b] === 1'b1) return;
        end
        bad_count++;
        $display("Error at %0t: timeout", $time);
        complete_run();
    endtask : wait_bit
    // Async frame, 32 clocks a bit
    task automatic send(input logic [7:0] d, input logic s);
        for (int i = 0; i < 10; i++)
        begin
            async_line <= (i == 0) ? 1'b0 : (i == 9) ? s : d[i - 1];
            repeat (32) @(posedge clock);
        end
        async_line <= 1'b1;
        repeat (64) @(posedge clock);
    endtask : send
    task automatic t_regs;
        wreg(2'h3, 8'hff);
        rreg(2'h3, v);
        chk(v, 0);
        rreg(2'h1, v);
        chk(v, 0);
        rreg(2'h2, v);
        chk(v, 0);
    endtask : t_regs
    task automatic t_m0;
        wreg(2'h1, 8'h20);
        wreg(2'h0, 8'ha5);
        wait_bit(spm_pkg::CTL_TI);
        chk(got, 8'ha5);
        chk(rxd_oe_b, 1'b1);
        wreg(2'h1, 8'h10);
        wait_bit(spm_pkg::CTL_RI);
        rreg(2'h0, v);
        chk(v, 8'h3c);
        wreg(2'h1, 8'h00);
    endtask : t_m0
    task automatic t_m2_tx;
        wreg(2'h2, 8'h80);
        wreg(2'h1, 8'h88);
        wreg(2'h0, 8'h5a);
        for (int i = 0; i < 600 && txd !== 1'b0; i++) @(posedge clock);
        if (txd !== 1'b0)
        begin
            bad_count++;
            $display("Error at %0t: no start bit", $time);
            complete_run();
        end
        repeat (8) @(posedge clock);
        for (int i = 0; i < 11; i++)
        begin
            frm[i] = txd;
            repeat (16) @(posedge clock);
        end
        chk(frm, {2'b11, 8'h5a, 1'b0});
        wait_bit(spm_pkg::CTL_TI);
        wreg(2'h1, 8'h00);
    endtask : t_m2_tx
    task automatic t_m1_rx;
        async_sel <= 1'b1;
        wreg(2'h1, 8'h70);
        send(8'hc3, 1'b0);
        // Short low pulse: a false start bit must be dropped
        async_line <= 1'b0;
        repeat (4) @(posedge clock);
        async_line <= 1'b1;
        repeat (64) @(posedge clock);
        rreg(2'h1, v);
        chk(v, 8'h70);
        send(8'h96, 1'b1);
        wait_bit(spm_pkg::CTL_RI);
        rreg(2'h0, v);
        chk(v, 8'h96);
        rreg(2'h1, v);
        chk(v, 8'h75);
    endtask : t_m1_rx
    initial
    begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_m0();
        t_m2_tx();
        t_m1_rx();
        complete_run();
    end
endmodule : serial_port_modes_0_to_2_bench
`default_nettype wire
